// [core/smc_regs.svh]
`ifndef SMC_REGS_SVH
`define SMC_REGS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define SMC_ADR_MODE 6'h00
`define SMC_ADR_OPTS 6'h04
`define SMC_ADR_PERIODS 6'h08
`define SMC_ADR_SLEEP 6'h0c
`define SMC_ADR_AWAKE 6'h10
`define SMC_ADR_STATUS 6'h14

// ----------------------------------------------------------------
// power-save selector codes
// ----------------------------------------------------------------
`define SMC_MODE_NORMAL 4'h0
`define SMC_MODE_PIN 4'h1
`define SMC_MODE_CYCLIC 4'h4
`define SMC_MODE_CYCPIN 4'h5
`define SMC_MODE_SUPPORT 4'h7
`define SMC_MODE_SYNC 4'h8

// ----------------------------------------------------------------
// option bits, limits and reset values
// ----------------------------------------------------------------
`define SMC_OPT_PREF_COORD 0
`define SMC_OPT_NON_COORD 1
`define SMC_OPT_API_STATUS 2
`define SMC_OPT_NO_EARLY 3
`define SMC_OPT_EQUALITY 4
`define SMC_OPT_NO_RAPID 5
`define SMC_OPT_FULL_WAKE 8
`define SMC_OPTS_MAX 9'h13e
`define SMC_OPTS_RST 9'h002
`define SMC_PERIODS_RST 16'h0001
`define SMC_SLEEP_MAX 22'h15f900
`define SMC_SLEEP_RST 22'h000190
`define SMC_AWAKE_MAX 22'h36ee80
`define SMC_AWAKE_RST 22'h001f40

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SMC_CLK_NS 10
`define SMC_MS_NS 1000000
`define SMC_MS_CYCLES (`SMC_MS_NS / `SMC_CLK_NS)
`define SMC_SLEEP_UNIT_MS 10
`define SMC_CHECK_MS 1

`endif

// [core/smc_pkg.sv]
package smc_pkg;

	typedef enum logic [2:0] {
		SMC_ST_AWAKE = 3'b000,
		SMC_ST_SLEEP = 3'b001,
		SMC_ST_CHECK = 3'b010,
		SMC_ST_FULL = 3'b011
	} smc_state_t;

	typedef struct packed {
		logic [3:0] mode;
		logic [8:0] opts;
		logic [15:0] periods;
		logic [21:0] sleep_dur;
		logic [21:0] awake_dur;
		smc_state_t st;
		logic [15:0] cnt;
		logic doze_q;
		logic ack;
		logic [31:0] dat;
		logic awake;
		logic asleep;
		logic coord;
		logic api_status;
		logic early_wake;
		logic equality;
		logic no_rapid;
	} smc_main_t;

	typedef struct packed {
		logic [16:0] pre;
		logic [24:0] left;
		logic run;
		logic done;
	} smc_timer_t;

endpackage : smc_pkg

// [core/smc_tmr_if.sv]
`timescale 1ns/10ps
interface smc_tmr_if;
	logic start;
	logic [24:0] load_ms;
	logic done;

	modport ctrl (output start, output load_ms, input done);
	modport tmr (input start, input load_ms, output done);
endinterface : smc_tmr_if

// [core/smc_timer.sv]
`timescale 1ns/10ps
`include "smc_regs.svh"
module smc_timer import smc_pkg::*; #(
	parameter logic [16:0] MS_CYCLES = 17'(`SMC_MS_CYCLES)
) (
	// clock, enable and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// control
	smc_tmr_if.tmr tm
);

	smc_timer_t r;
	smc_timer_t nxt;

	// ----------------------------------------------------------------
	// millisecond down-counter
	// ----------------------------------------------------------------
	always_comb begin
		nxt = r;
		nxt.done = 1'b0;
		if (tm.start) begin
			nxt.pre = 17'h00000;
			nxt.left = tm.load_ms;
			nxt.run = 1'b1;
		end else if (r.run) begin
			if (r.pre == MS_CYCLES - 17'h00001) begin
				nxt.pre = 17'h00000;
				// zero load still yields one tick, never a hang
				if (r.left <= 25'h0000001) begin
					nxt.run = 1'b0;
					nxt.done = 1'b1;
				end else begin
					nxt.left = r.left - 25'h0000001;
				end
			end else begin
				nxt.pre = r.pre + 17'h00001;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '0;
		end else if (ce_i) begin
			r <= nxt;
		end
	end

	assign tm.done = r.done;

endmodule : smc_timer

// [core/smc_top.sv]
// What this block does
// [R1] selector takes 0,1,4,5,7,8 only; resets 0
// [R2] code 0: always awake, never sleeps
// [R3] code 1: doze input level sets sleep
// [R4] code 4: sleep duration, then awake duration
// [R5] code 5: falling doze edge ends sleep
// [R6] software never sets option bits 0,1 together
// [R7] option mask accepts zero to 0x13e
// [R8] bit 0: sleep-compatible device coordinates always
// [R9] bit 1: never coordinate; mask resets 0x2
// [R10] bit 2: framed sleep status messages
// [R11] bit 3: no early wake on missed syncs
// [R12] bit 4: node types equal, no seniority
// [R13] bit 5: rapid-sync deployment disabled
// [R14] bit 8: full awake duration every cycle
// [R15] indicator once per N sleep periods, reset 1
// [R16] other cycles: brief check, data wakes fully
// [R17] no data: back to sleep, indicator low
// [R18] period count ignored in synchronous sleep
// [R19] sleep duration 10 ms units, 1..0x15f900
// [R20] awake duration 1 ms units; data restarts it except in code 8
// [R21] indicator high only while fully awake
`timescale 1ns/10ps
`include "smc_regs.svh"
module smc_top import smc_pkg::*; #(
	parameter logic [16:0] MS_CYCLES = 17'(`SMC_MS_CYCLES)
) (
	// clock, enable, reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// host and radio side
	input wire logic doze_req_i,
	input wire logic data_pending_i,
	input wire logic sync_missed_i,
	// power state
	output logic awake_o,
	output logic asleep_o,
	// option outputs
	output logic coord_o,
	output logic api_status_o,
	output logic early_wake_o,
	output logic equality_o,
	output logic no_rapid_o
);

	smc_main_t r;
	smc_main_t nxt;
	logic tm_start;
	logic [24:0] tm_load;
	logic wr_ok;
	logic rd_ok;
	logic cyclic;
	logic fall;
	logic [16:0] cnt_inc;

	smc_tmr_if tm ();

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic mode_legal(input logic [3:0] m);
		return m == `SMC_MODE_NORMAL || m == `SMC_MODE_PIN ||
			m == `SMC_MODE_CYCLIC || m == `SMC_MODE_CYCPIN ||
			m == `SMC_MODE_SUPPORT || m == `SMC_MODE_SYNC;
	endfunction : mode_legal

	function automatic logic [24:0] sleep_ms(input logic [21:0] v);
		return 25'(v) * 25'(`SMC_SLEEP_UNIT_MS);
	endfunction : sleep_ms

	function automatic logic [31:0] lane(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return res;
	endfunction : lane

	smc_timer #(
		.MS_CYCLES(MS_CYCLES)
	) u_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.tm(tm.tmr)
	);

	assign tm.start = tm_start;
	assign tm.load_ms = tm_load;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [31:0] wv;
		wv = 32'h00000000;
		nxt = r;
		tm_start = 1'b0;
		tm_load = 25'h0000000;
		wr_ok = wb_cyc_i && wb_stb_i && !r.ack;
		rd_ok = wr_ok && !wb_we_i;
		cyclic = r.mode == `SMC_MODE_CYCLIC ||
			r.mode == `SMC_MODE_CYCPIN || r.mode == `SMC_MODE_SYNC;
		fall = r.doze_q && !doze_req_i;
		cnt_inc = {1'b0, r.cnt} + 17'h00001;
		nxt.doze_q = doze_req_i;
		nxt.ack = wr_ok;
		nxt.dat = 32'h00000000;

		// bus writes; illegal values leave the register untouched
		if (wr_ok && wb_we_i) begin
			case (wb_adr_i)
				`SMC_ADR_MODE: begin
					wv = lane({28'h0000000, r.mode}, wb_dat_i, wb_sel_i);
					if (wv[31:4] == 28'h0000000 && mode_legal(wv[3:0])) begin
						nxt.mode = wv[3:0]; // see [R1]
					end
				end
				`SMC_ADR_OPTS: begin
					wv = lane({23'h000000, r.opts}, wb_dat_i, wb_sel_i);
					// both coordinator bits set is a software fault
					if (wv <= 32'(`SMC_OPTS_MAX) && !(wv[0] && wv[1])) begin
						nxt.opts = wv[8:0]; // see [R7] see [R6]
					end
				end
				`SMC_ADR_PERIODS: begin
					wv = lane({16'h0000, r.periods}, wb_dat_i, wb_sel_i);
					if (wv[31:16] == 16'h0000 && wv[15:0] != 16'h0000) begin
						nxt.periods = wv[15:0]; // see [R15]
					end
				end
				`SMC_ADR_SLEEP: begin
					wv = lane({10'h000, r.sleep_dur}, wb_dat_i, wb_sel_i);
					if (wv != 32'h00000000 && wv <= 32'(`SMC_SLEEP_MAX)) begin
						nxt.sleep_dur = wv[21:0]; // see [R19]
					end
				end
				`SMC_ADR_AWAKE: begin
					wv = lane({10'h000, r.awake_dur}, wb_dat_i, wb_sel_i);
					if (wv != 32'h00000000 && wv <= 32'(`SMC_AWAKE_MAX)) begin
						nxt.awake_dur = wv[21:0]; // see [R20]
					end
				end
				default: begin
				end
			endcase
		end

		// bus reads; unmapped words read zero and still ack
		if (rd_ok) begin
			case (wb_adr_i)
				`SMC_ADR_MODE: nxt.dat = {28'h0000000, r.mode};
				`SMC_ADR_OPTS: nxt.dat = {23'h000000, r.opts};
				`SMC_ADR_PERIODS: nxt.dat = {16'h0000, r.periods};
				`SMC_ADR_SLEEP: nxt.dat = {10'h000, r.sleep_dur};
				`SMC_ADR_AWAKE: nxt.dat = {10'h000, r.awake_dur};
				`SMC_ADR_STATUS: begin
					nxt.dat = {11'h000, r.awake, r.asleep, r.st, r.cnt};
				end
				default: nxt.dat = 32'h00000000;
			endcase
		end

		// ----------------------------------------------------------------
		// sleep sequencer
		// ----------------------------------------------------------------
		case (r.st)
			SMC_ST_AWAKE: begin
				if (r.mode == `SMC_MODE_PIN && doze_req_i) begin
					nxt.st = SMC_ST_SLEEP; // see [R3]
				end else if (cyclic) begin
					nxt.st = SMC_ST_SLEEP; // see [R4]
					nxt.cnt = 16'h0000;
					tm_start = 1'b1;
					tm_load = sleep_ms(r.sleep_dur); // see [R19]
				end
			end
			SMC_ST_SLEEP: begin
				if (r.mode == `SMC_MODE_NORMAL ||
					r.mode == `SMC_MODE_SUPPORT) begin
					nxt.st = SMC_ST_AWAKE; // see [R2]
				end else if (r.mode == `SMC_MODE_PIN) begin
					if (!doze_req_i) begin
						nxt.st = SMC_ST_AWAKE; // see [R3]
					end
				end else if (r.mode == `SMC_MODE_SYNC) begin
					// period count plays no part here
					if (tm.done || (sync_missed_i &&
						!r.opts[`SMC_OPT_NO_EARLY])) begin
						nxt.st = SMC_ST_FULL; // see [R18] see [R11]
						tm_start = 1'b1;
						tm_load = 25'(r.awake_dur);
					end
				end else if (r.mode == `SMC_MODE_CYCPIN && fall) begin
					nxt.st = SMC_ST_FULL; // see [R5]
					nxt.cnt = 16'h0000;
					tm_start = 1'b1;
					tm_load = 25'(r.awake_dur);
				end else if (tm.done) begin
					if (cnt_inc >= {1'b0, r.periods}) begin
						nxt.st = SMC_ST_FULL; // see [R15]
						nxt.cnt = 16'h0000;
						tm_start = 1'b1;
						tm_load = 25'(r.awake_dur); // see [R4]
					end else begin
						nxt.st = SMC_ST_CHECK; // see [R16]
						nxt.cnt = cnt_inc[15:0];
						tm_start = 1'b1;
						tm_load = 25'(`SMC_CHECK_MS);
					end
				end
			end
			SMC_ST_CHECK: begin
				if (!cyclic) begin
					nxt.st = SMC_ST_AWAKE;
				end else if (data_pending_i) begin
					nxt.st = SMC_ST_FULL; // see [R16]
					nxt.cnt = 16'h0000;
					tm_start = 1'b1;
					tm_load = 25'(r.awake_dur);
				end else if (tm.done) begin
					nxt.st = SMC_ST_SLEEP; // see [R17]
					tm_start = 1'b1;
					tm_load = sleep_ms(r.sleep_dur);
				end
			end
			SMC_ST_FULL: begin
				if (!cyclic) begin
					nxt.st = SMC_ST_AWAKE;
				end else if (tm.done || (doze_req_i &&
					!r.opts[`SMC_OPT_FULL_WAKE])) begin
					// host may cut a wake short unless held full
					nxt.st = SMC_ST_SLEEP; // see [R14]
					tm_start = 1'b1;
					tm_load = sleep_ms(r.sleep_dur);
				end else if (data_pending_i && r.mode != `SMC_MODE_SYNC) begin
					tm_start = 1'b1; // see [R20]
					tm_load = 25'(r.awake_dur);
				end
			end
			default: begin
				nxt.st = SMC_ST_AWAKE;
			end
		endcase

		// a cyclic code written during pin sleep finds no sleep timer running
		if (r.mode == `SMC_MODE_PIN && r.st == SMC_ST_SLEEP &&
			nxt.st == SMC_ST_SLEEP && nxt.mode != r.mode) begin
			nxt.cnt = 16'h0000; // see [R4]
			tm_start = 1'b1;
			tm_load = sleep_ms(r.sleep_dur);
		end

		// indicator tracks the state it is registered with
		nxt.awake = nxt.st == SMC_ST_AWAKE || nxt.st == SMC_ST_FULL; // see [R21]
		nxt.asleep = nxt.st == SMC_ST_SLEEP;
		nxt.coord = (r.mode == `SMC_MODE_SUPPORT ||
			r.mode == `SMC_MODE_SYNC) && r.opts[`SMC_OPT_PREF_COORD] &&
			!r.opts[`SMC_OPT_NON_COORD]; // see [R8] see [R9]
		nxt.api_status = r.opts[`SMC_OPT_API_STATUS]; // see [R10]
		nxt.early_wake = !r.opts[`SMC_OPT_NO_EARLY]; // see [R11]
		nxt.equality = r.opts[`SMC_OPT_EQUALITY]; // see [R12]
		nxt.no_rapid = r.opts[`SMC_OPT_NO_RAPID]; // see [R13]
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '0;
			r.mode <= `SMC_MODE_NORMAL; // see [R1]
			r.opts <= `SMC_OPTS_RST; // see [R9]
			r.periods <= `SMC_PERIODS_RST;
			r.sleep_dur <= `SMC_SLEEP_RST;
			r.awake_dur <= `SMC_AWAKE_RST;
			r.st <= SMC_ST_AWAKE;
			r.awake <= 1'b1;
			r.early_wake <= 1'b1;
		end else if (ce_i) begin
			r <= nxt;
		end
	end

	assign wb_dat_o = r.dat;
	assign wb_ack_o = r.ack;
	assign awake_o = r.awake;
	assign asleep_o = r.asleep;
	assign coord_o = r.coord;
	assign api_status_o = r.api_status;
	assign early_wake_o = r.early_wake;
	assign equality_o = r.equality;
	assign no_rapid_o = r.no_rapid;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence brief_check_s;
		ce_i && cyclic && r.st == SMC_ST_CHECK && !data_pending_i && tm.done;
	endsequence

	mode_legal_a: assert property (mode_legal(r.mode)) // see [R1]
		else $error("selector holds an illegal code");
	normal_awake_a: assert property ( // see [R2]
		ce_i && r.mode == `SMC_MODE_NORMAL |=> awake_o && !asleep_o)
		else $error("normal mode not awake");
	pin_sleep_a: assert property ( // see [R3]
		ce_i && r.mode == `SMC_MODE_PIN && doze_req_i &&
		r.st == SMC_ST_AWAKE |=> asleep_o && !awake_o)
		else $error("pin sleep not entered");
	pin_wake_a: assert property ( // see [R5]
		ce_i && r.mode == `SMC_MODE_CYCPIN && r.st == SMC_ST_SLEEP &&
		r.doze_q && !doze_req_i |=> awake_o)
		else $error("falling doze edge did not wake");
	opts_range_a: assert property ( // see [R7]
		r.opts <= `SMC_OPTS_MAX && !(r.opts[0] && r.opts[1]))
		else $error("option mask out of range");
	coord_role_a: assert property ( // see [R9]
		ce_i && r.opts[`SMC_OPT_NON_COORD] |=> !coord_o)
		else $error("coordinator taken despite bit 1");
	check_sleep_a: assert property ( // see [R17]
		brief_check_s |=> asleep_o && !awake_o)
		else $error("idle check did not return to sleep");
	count_step_a: assert property ( // see [R15]
		ce_i && r.mode == `SMC_MODE_CYCLIC && r.st == SMC_ST_SLEEP &&
		tm.done && {1'b0, r.cnt} + 17'h00001 < {1'b0, r.periods}
		|=> r.st == SMC_ST_CHECK && !awake_o)
		else $error("early full wake before period count");
	sleep_range_a: assert property ( // see [R19]
		r.sleep_dur != 22'h000000 && r.sleep_dur <= `SMC_SLEEP_MAX)
		else $error("sleep duration out of range");
	sync_hold_a: assert property ( // see [R11]
		ce_i && r.mode == `SMC_MODE_SYNC && r.st == SMC_ST_SLEEP &&
		sync_missed_i && r.opts[`SMC_OPT_NO_EARLY] && !tm.done
		|=> asleep_o && !awake_o)
		else $error("missed sync woke despite bit 3");

endmodule : smc_top

// [bench/smc_host_model.sv]
`timescale 1ns/10ps
// ----------------------------------------
// host side: owner of the doze request pin
// ----------------------------------------
module smc_host_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bench control
	input wire logic want_sleep_i,
	input wire logic slow_i,
	// doze request pin
	output logic doze_req_o
);
	logic lag_r;

	// a slow host answers one cycle later; the pin is a held level
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lag_r <= 1'b0;
			doze_req_o <= 1'b0;
		end else begin
			lag_r <= want_sleep_i;
			doze_req_o <= slow_i ? lag_r : want_sleep_i;
		end
	end
endmodule : smc_host_model

// [bench/tb_sleep_mode_controller.sv]
`timescale 1ns/10ps
`include "smc_regs.svh"
module tb_sleep_mode_controller import smc_pkg::*;;
	localparam int MSC = 4;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [5:0] adr = 6'h00;
	logic [31:0] wdat = 32'h0;
	logic want = 1'b0;
	logic slow = 1'b0;
	logic data = 1'b0;
	logic miss = 1'b0;
	logic doze, ack, awake, asleep, coord, api, early, equal, norapid;
	logic [31:0] rdat, rd, eo, v, em;
	int error_cnt = 0;
	int tests_run = 0;
	int seed = 94;
	int n;

	always #5 clk_i = ~clk_i;

	smc_top #(.MS_CYCLES(17'(MSC))) dut (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.doze_req_i(doze), .data_pending_i(data), .sync_missed_i(miss),
		.awake_o(awake), .asleep_o(asleep), .coord_o(coord),
		.api_status_o(api), .early_wake_o(early), .equality_o(equal),
		.no_rapid_o(norapid)
	);

	smc_host_model host (.clk_i(clk_i), .rst_i(rst_i), .want_sleep_i(want),
		.slow_i(slow), .doze_req_o(doze));

	// ----------------------------------------
	// expectations and bus helpers
	// ----------------------------------------
	function automatic logic [31:0] mode_exp(logic [31:0] m, logic [31:0] o);
		return (m[3:0] inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h7, 4'h8}) ? m : o;
	endfunction : mode_exp

	function automatic logic opt_ok(logic [31:0] x);
		return x <= 32'h13e && x[1:0] != 2'b11;
	endfunction : opt_ok

	function automatic logic [4:0] opt_out(logic [31:0] x);
		return {x[0] & ~x[1], x[2], ~x[3], x[4], x[5]};
	endfunction : opt_out

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk

	// request held until ack is sampled high at a rising edge
	task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 20);
		rd = rdat;
		if (k >= 20) chk(32'(ack), 32'h1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : xfer

	task automatic rreg(input logic [5:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rreg

	task automatic dur_chk(input logic [5:0] a, input logic [31:0] mx,
		input logic [31:0] rv);
		xfer(1'b1, a, 32'h0);
		rreg(a, rv);
		xfer(1'b1, a, mx + 32'h1);
		rreg(a, rv);
		xfer(1'b1, a, mx);
		rreg(a, mx);
	endtask : dur_chk

	// cycles until awake (s=0) or asleep (s=1) shows level l
	task automatic wait_lvl(input logic s, input logic l, input int lo,
		input int hi);
		int k;
		k = 0;
		while ((s ? asleep : awake) !== l && k <= hi) begin
			@(posedge clk_i);
			k++;
		end
		chk(32'(k >= lo && k <= hi), 32'h1);
	endtask : wait_lvl

	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk(32'({awake, asleep, coord, early}), 32'h9);
		rreg(`SMC_ADR_MODE, 32'h0);
		rreg(`SMC_ADR_OPTS, 32'h2);
		rreg(`SMC_ADR_PERIODS, 32'h1);
		rreg(`SMC_ADR_SLEEP, 32'h190);
		rreg(`SMC_ADR_AWAKE, 32'h1f40);
		em = 32'h0;
		for (int m = 0; m < 16; m++) begin
			em = mode_exp(32'(m), em);
			xfer(1'b1, `SMC_ADR_MODE, 32'(m));
			rreg(`SMC_ADR_MODE, em);
		end
		xfer(1'b1, `SMC_ADR_MODE, 32'h7);
		eo = 32'h2;
		for (int i = 0; i < 12; i++) begin
			v = (i == 0) ? 32'h13d : (i == 1) ? 32'h13f : (i == 2) ? 32'h3 :
				32'($random(seed)) & 32'h1ff;
			if (opt_ok(v))
				eo = v;
			xfer(1'b1, `SMC_ADR_OPTS, v);
			rreg(`SMC_ADR_OPTS, eo);
			em = 32'(opt_out(eo));
			chk(32'(coord), 32'(em[4]));
			chk(32'(api), 32'(em[3]));
			chk(32'(early), 32'(em[2]));
			chk(32'(equal), 32'(em[1]));
			chk(32'(norapid), 32'(em[0]));
		end
		dur_chk(`SMC_ADR_SLEEP, 32'h15f900, 32'h190);
		dur_chk(`SMC_ADR_AWAKE, 32'h36ee80, 32'h1f40);
		xfer(1'b1, `SMC_ADR_OPTS, 32'h2);
		xfer(1'b1, `SMC_ADR_SLEEP, 32'h2);
		xfer(1'b1, `SMC_ADR_AWAKE, 32'h4);
		// doze request must not matter in code 0
		xfer(1'b1, `SMC_ADR_MODE, 32'h0);
		want <= 1'b1;
		n = 0;
		repeat (150) begin
			@(posedge clk_i);
			if (awake !== 1'b1)
				n++;
		end
		chk(32'(n), 32'h0);
		slow <= 1'($random(seed));
		xfer(1'b1, `SMC_ADR_MODE, 32'h1);
		wait_lvl(1'b0, 1'b0, 0, 5);
		chk(32'(asleep), 32'h1);
		want <= 1'b0;
		wait_lvl(1'b0, 1'b1, 0, 5);
		// cyclic, one period per full wake: 80 cycles asleep, 16 awake
		xfer(1'b1, `SMC_ADR_MODE, 32'h4);
		wait_lvl(1'b0, 1'b0, 0, 4);
		wait_lvl(1'b0, 1'b1, 78, 92);
		wait_lvl(1'b0, 1'b0, 14, 24);
		// three periods: two silent checks, then one full wake
		xfer(1'b1, `SMC_ADR_PERIODS, 32'h3);
		wait_lvl(1'b0, 1'b1, 230, 275);
		wait_lvl(1'b0, 1'b0, 14, 24);
		wait_lvl(1'b1, 1'b0, 78, 92);
		chk(32'(awake), 32'h0);
		data <= 1'b1;
		wait_lvl(1'b0, 1'b1, 0, 4);
		data <= 1'b0;
		wait_lvl(1'b0, 1'b0, 14, 26);
		// pin wake-up cuts a 200 cycle sleep short
		xfer(1'b1, `SMC_ADR_PERIODS, 32'h1);
		xfer(1'b1, `SMC_ADR_SLEEP, 32'h5);
		xfer(1'b1, `SMC_ADR_AWAKE, 32'ha);
		want <= 1'b1;
		xfer(1'b1, `SMC_ADR_MODE, 32'h0);
		wait_lvl(1'b0, 1'b1, 0, 4);
		xfer(1'b1, `SMC_ADR_MODE, 32'h5);
		wait_lvl(1'b0, 1'b0, 0, 4);
		repeat (20) @(posedge clk_i);
		slow <= 1'($random(seed));
		want <= 1'b0;
		wait_lvl(1'b0, 1'b1, 0, 6);
		want <= 1'b1;
		wait_lvl(1'b0, 1'b0, 0, 6);
		// synchronous: periods ignored, full awake time despite doze
		xfer(1'b1, `SMC_ADR_MODE, 32'h0);
		wait_lvl(1'b0, 1'b1, 0, 4);
		xfer(1'b1, `SMC_ADR_OPTS, 32'h102);
		xfer(1'b1, `SMC_ADR_PERIODS, 32'h3);
		xfer(1'b1, `SMC_ADR_SLEEP, 32'h2);
		xfer(1'b1, `SMC_ADR_MODE, 32'h8);
		wait_lvl(1'b0, 1'b0, 0, 4);
		wait_lvl(1'b0, 1'b1, 78, 92);
		wait_lvl(1'b0, 1'b0, 38, 48);
		// missed sync wakes early unless option bit 3 holds it off
		repeat (10) @(posedge clk_i);
		miss <= 1'b1;
		wait_lvl(1'b0, 1'b1, 0, 4);
		miss <= 1'b0;
		wait_lvl(1'b0, 1'b0, 38, 48);
		xfer(1'b1, `SMC_ADR_OPTS, 32'h10a);
		miss <= 1'b1;
		n = 0;
		repeat (20) begin
			@(posedge clk_i);
			if (awake !== 1'b0)
				n++;
		end
		miss <= 1'b0;
		chk(32'(n), 32'h0);
		chk(32'(early), 32'h0);
		tally_and_finish();
	end

	// hang guard, well beyond the little over a thousand cycles needed
	initial begin
		#200000;
		error_cnt++;
		$display("mismatch at %0t: run did not finish", $time);
		tally_and_finish();
	end
endmodule : tb_sleep_mode_controller
